// ---- hw/hpsr_consts.svh ----
// Register indices, field positions, reset values and timing for hub port suspend/resume
`ifndef HPSR_CONSTS_SVH
`define HPSR_CONSTS_SVH

// ********************************************************************
// Register indices (byte address is four times the index)
// ********************************************************************
`define HPSR_IDX_USC   8'h1f
`define HPSR_IDX_DSCTL 8'h4b
`define HPSR_IDX_SUSP  8'h4d
`define HPSR_IDX_RES   8'h4e
`define HPSR_IDX_DATA  8'h50

// ********************************************************************
// Fields and reset values
// ********************************************************************
`define HPSR_NP        4
`define HPSR_RST8      8'h00
`define HPSR_BIT_WAKE  7
`define HPSR_BIT_BA    3
`define HPSR_UA_SIE    3'h0
`define HPSR_UA_DIFF1  3'h1
`define HPSR_UA_DIFF0  3'h2
`define HPSR_UA_SE0    3'h3
`define HPSR_UA_LOW    3'h4
`define HPSR_UA_ZLO    3'h5
`define HPSR_UA_LOZ    3'h6
`define HPSR_UA_ZZ     3'h7
`define HPSR_DC_NORM   2'h0
`define HPSR_DC_DIFF1  2'h1
`define HPSR_DC_DIFF0  2'h2
`define HPSR_DC_SE0    2'h3

// ********************************************************************
// Timing
// ********************************************************************
`define HPSR_CLK_NS    50
`define HPSR_KDET_NS   2500
`define HPSR_WAKE_NS   1000000
`define HPSR_UPK_NS    1000000

`endif

// ---- hw/hpsr_pkg.sv ----
// Types shared by the hub port suspend/resume block
package hpsr_pkg;

  // ********************************************************************
  // Line sense and line drive
  // ********************************************************************
  typedef struct packed {
    logic dp;
    logic dm;
  } hpsr_line_t;

  typedef struct packed {
    logic dpO;
    logic dmO;
    logic dpOe;
    logic dmOe;
  } hpsr_drv_t;

  // ********************************************************************
  // AHB-Lite slave carriers
  // ********************************************************************
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
  } hpsr_ahb_req_t;

  typedef struct packed {
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
  } hpsr_ahb_rsp_t;

  typedef enum logic [0:0] {
    WK_IDLE,
    WK_HOLD
  } hpsr_wake_t;

endpackage

// ---- hw/hpsr_top.sv ----
// Downstream port suspend/resume and upstream status/control logic of the hub
//
// The AHB-Lite slave port is this design's own decision.
`include "hpsr_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module hpsr_top #(
  parameter int WAKE_HOLD_CYC = (`HPSR_WAKE_NS + `HPSR_CLK_NS - 1) / `HPSR_CLK_NS,
  parameter int UPK_CYC       = (`HPSR_UPK_NS + `HPSR_CLK_NS - 1) / `HPSR_CLK_NS
) (
  // Clock and resets
  input  wire logic                          mclk,
  input  wire logic                          rstn,
  input  wire logic                          busReset,
  // Register bus
  input  wire hpsr_pkg::hpsr_ahb_req_t       ahbReq,
  output var  hpsr_pkg::hpsr_ahb_rsp_t       ahbRsp,
  // Downstream ports
  input  wire hpsr_pkg::hpsr_line_t [3:0]    dsLine,
  input  wire hpsr_pkg::hpsr_drv_t  [3:0]    rptDrv,
  input  wire logic [3:0]                    portEnable,
  input  wire logic [3:0]                    portLowSpeed,
  input  wire logic [3:0]                    portConnected,
  input  wire logic [3:0]                    connEvt,
  input  wire logic [3:0]                    discEvt,
  output var  hpsr_pkg::hpsr_drv_t  [3:0]    dsDrv,
  output var  logic [3:0]                    dsTrafficEn,
  output var  logic [3:0]                    dsLowRate,
  output var  logic [3:0]                    newConnect,
  // Upstream port
  input  wire hpsr_pkg::hpsr_line_t          usLine,
  input  wire hpsr_pkg::hpsr_drv_t           sieDrv,
  input  wire logic                          sieActivity,
  output var  hpsr_pkg::hpsr_drv_t           usDrv,
  output var  logic [1:0]                    epSizeMode,
  // Hub power and events
  input  wire logic                          hubSuspended,
  output var  logic                          hubIrq,
  output var  logic                          leaveSuspend,
  output var  logic                          cpuHold,
  output var  logic                          upResumeActive
);
  import hpsr_pkg::*;

  // ********************************************************************
  // Timing constants
  // ********************************************************************
  localparam int KDET_CYC = (`HPSR_KDET_NS + `HPSR_CLK_NS - 1) / `HPSR_CLK_NS;
  localparam int KW       = $clog2(KDET_CYC + 1);
  localparam int HW       = $clog2(WAKE_HOLD_CYC + 1);
  localparam int UW       = $clog2(UPK_CYC + 1);

  // ********************************************************************
  // Functions
  // ********************************************************************
  // K is J inverted; J idles high on D- for low speed, on D+ for full
  function automatic logic isK(input hpsr_line_t ln, input logic ls);
    isK = ls ? (ln.dp & ~ln.dm) : (~ln.dp & ln.dm);
  endfunction

  function automatic hpsr_drv_t drvK(input logic ls);
    drvK = ls ? 4'b1011 : 4'b0111;
  endfunction

  function automatic logic [KW-1:0] kCount(input logic k, input logic [KW-1:0] c);
    if (!k) begin
      kCount = '0;
    end else if (c == KW'(KDET_CYC)) begin
      kCount = c;
    end else begin
      kCount = c + KW'(1);
    end
  endfunction

  // ********************************************************************
  // Registers
  // ********************************************************************
  logic [7:0]      usc_r;
  logic [7:0]      susp_r;
  logic [7:0]      susp_nxt;
  logic [3:0]      resSt_r;
  logic [3:0]      resSt_nxt;
  logic [7:0]      dsCtl_r;
  logic [3:0]      diff_r;
  logic            wrPend_r;
  logic            rdPend_r;
  logic [7:0]      idx_r;
  logic [KW-1:0]   kCnt_r [4];
  logic [KW-1:0]   usCnt_r;
  logic [UW-1:0]   upCnt_r;
  logic [HW-1:0]   holdCnt_r;
  hpsr_wake_t      wk_r;
  hpsr_wake_t      wk_nxt;
  logic            resumeAll_r;
  hpsr_drv_t [3:0] dsDrv_nxt;
  hpsr_drv_t       usDrv_nxt;

  // ********************************************************************
  // Bus decode
  // ********************************************************************
  wire        addrOk   = ahbReq.hsel & ahbReq.htrans[1] & ahbRsp.hreadyout;
  wire [7:0]  wdata    = ahbReq.hwdata[7:0];
  wire        wrUsc    = wrPend_r & (idx_r == `HPSR_IDX_USC);
  wire        wrSusp   = wrPend_r & (idx_r == `HPSR_IDX_SUSP);
  wire        wrDsCtl  = wrPend_r & (idx_r == `HPSR_IDX_DSCTL);
  wire [7:0]  rdMux    = (idx_r == `HPSR_IDX_USC)   ? usc_r :
                         (idx_r == `HPSR_IDX_SUSP)  ? susp_r :
                         (idx_r == `HPSR_IDX_RES)   ? {4'h0, resSt_r} :
                         (idx_r == `HPSR_IDX_DATA)  ? {4'h0, diff_r} :
                         (idx_r == `HPSR_IDX_DSCTL) ? dsCtl_r : `HPSR_RST8;

  // ********************************************************************
  // Line sensing
  // ********************************************************************
  logic [3:0] kNow;
  logic [3:0] kDet;
  logic [3:0] se0;
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      kNow[p] = isK(dsLine[p], portLowSpeed[p]);
      kDet[p] = kNow[p] & (kCnt_r[p] == KW'(KDET_CYC - 1));
      se0[p]  = ~dsLine[p].dp & ~dsLine[p].dm;
    end
  end

  wire usKNow  = isK(usLine, 1'b0);
  wire usKDet  = usKNow & (usCnt_r == KW'(KDET_CYC - 1));
  wire usKHeld = usKNow & (usCnt_r == KW'(KDET_CYC));

  // ********************************************************************
  // Suspend and resume status
  // ********************************************************************
  wire [3:0] resSet = kDet & susp_r[3:0];
  always_comb begin
    susp_nxt = wrSusp ? wdata : susp_r;
    susp_nxt[3:0] = susp_nxt[3:0] & ~discEvt;
    // Status lives only while the port stays suspended
    resSt_nxt = (resSt_r | resSet) & susp_nxt[3:0];
  end

  // ********************************************************************
  // Hub level wake events
  // ********************************************************************
  wire portChg   = |(connEvt | discEvt);
  wire dsWake    = hubSuspended & (|kDet);
  wire chgWake   = hubSuspended & portChg & susp_r[`HPSR_BIT_WAKE];
  wire hostRes   = hubSuspended & usKDet;
  wire wakeEvt   = hubSuspended & (portChg | (|kDet) | usKDet);
  wire upStart   = dsWake | chgWake;
  wire resumeAll = (upCnt_r != '0) | usKHeld;
  wire resEnd    = resumeAll_r & ~resumeAll;

  always_comb begin
    wk_nxt = wk_r;
    unique case (wk_r)
      WK_IDLE: begin
        if (wakeEvt) begin
          wk_nxt = WK_HOLD;
        end
      end
      WK_HOLD: begin
        if (holdCnt_r == '0 && !wakeEvt) begin
          wk_nxt = WK_IDLE;
        end
      end
    endcase
  end

  // ********************************************************************
  // Port drive selection
  // ********************************************************************
  wire [2:0] upAct = usc_r[2:0];
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      unique case (dsCtl_r[2*p +: 2])
        `HPSR_DC_DIFF1: dsDrv_nxt[p] = 4'b1011;
        `HPSR_DC_DIFF0: dsDrv_nxt[p] = 4'b0111;
        `HPSR_DC_SE0:   dsDrv_nxt[p] = 4'b0011;
        `HPSR_DC_NORM: begin
          if (resSt_r[p]) begin
            dsDrv_nxt[p] = drvK(portLowSpeed[p]);
          end else if (susp_r[p]) begin
            dsDrv_nxt[p] = 4'b0000;
          end else if (resumeAll & portEnable[p]) begin
            dsDrv_nxt[p] = drvK(portLowSpeed[p]);
          end else begin
            dsDrv_nxt[p] = rptDrv[p];
          end
        end
      endcase
    end
    unique case (upAct)
      `HPSR_UA_SIE: usDrv_nxt = (upCnt_r != '0) ? drvK(1'b0) : sieDrv;
      `HPSR_UA_DIFF1: usDrv_nxt = 4'b1011;
      `HPSR_UA_DIFF0: usDrv_nxt = 4'b0111;
      `HPSR_UA_SE0:   usDrv_nxt = 4'b0011;
      `HPSR_UA_LOW:   usDrv_nxt = 4'b0011;
      `HPSR_UA_ZLO:   usDrv_nxt = 4'b0001;
      `HPSR_UA_LOZ:   usDrv_nxt = 4'b0010;
      `HPSR_UA_ZZ:    usDrv_nxt = 4'b0000;
    endcase
  end

  // ********************************************************************
  // Bus slave flops
  // ********************************************************************
  // Reads take one wait state so a write just committed is seen
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wrPend_r <= 1'b0;
      rdPend_r <= 1'b0;
      idx_r    <= 8'h00;
      ahbRsp   <= '{hreadyout: 1'b1, hresp: 1'b0, hrdata: 32'h0000_0000};
    end else begin
      wrPend_r <= addrOk & ahbReq.hwrite;
      rdPend_r <= addrOk & ~ahbReq.hwrite;
      if (addrOk) begin
        idx_r <= ahbReq.haddr[9:2];
      end
      ahbRsp.hreadyout <= ~(addrOk & ~ahbReq.hwrite);
      if (rdPend_r) begin
        ahbRsp.hrdata <= {24'h00_0000, rdMux};
      end
    end
  end

  // ********************************************************************
  // Register flops
  // ********************************************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      usc_r   <= `HPSR_RST8;
      dsCtl_r <= `HPSR_RST8;
    end else begin
      if (wrUsc) begin
        usc_r[7:6] <= wdata[7:6];
        usc_r[2:0] <= wdata[2:0];
      end
      usc_r[5:4] <= {usLine.dp, usLine.dm};
      // Activity set wins over a clearing write
      usc_r[`HPSR_BIT_BA] <= sieActivity |
        (usc_r[`HPSR_BIT_BA] & ~(wrUsc & ~wdata[`HPSR_BIT_BA]));
      if (wrDsCtl) begin
        dsCtl_r <= wdata;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      susp_r  <= `HPSR_RST8;
      resSt_r <= 4'h0;
      diff_r  <= 4'h0;
    end else if (busReset) begin
      susp_r  <= `HPSR_RST8;
      resSt_r <= 4'h0;
      diff_r  <= 4'h0;
    end else begin
      susp_r  <= susp_nxt;
      resSt_r <= resSt_nxt;
      for (int p = 0; p < 4; p++) begin
        if (dsLine[p].dp ^ dsLine[p].dm) begin
          diff_r[p] <= dsLine[p].dp;
        end
      end
    end
  end

  // ********************************************************************
  // Detection and wake flops
  // ********************************************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int p = 0; p < 4; p++) begin
        kCnt_r[p] <= '0;
      end
      usCnt_r     <= '0;
      upCnt_r     <= '0;
      holdCnt_r   <= '0;
      wk_r        <= WK_IDLE;
      resumeAll_r <= 1'b0;
    end else begin
      for (int p = 0; p < 4; p++) begin
        kCnt_r[p] <= kCount(kNow[p], kCnt_r[p]);
      end
      usCnt_r     <= kCount(usKNow, usCnt_r);
      resumeAll_r <= resumeAll;
      if (upStart) begin
        upCnt_r <= UW'(UPK_CYC);
      end else if (upCnt_r != '0) begin
        upCnt_r <= upCnt_r - UW'(1);
      end
      wk_r <= wk_nxt;
      // A fresh wake restarts the hold so a late event is not cut short
      if (wk_r == WK_IDLE || wakeEvt) begin
        holdCnt_r <= HW'(WAKE_HOLD_CYC - 1);
      end else if (holdCnt_r != '0) begin
        holdCnt_r <= holdCnt_r - HW'(1);
      end
    end
  end

  // ********************************************************************
  // Output flops
  // ********************************************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dsDrv          <= '0;
      usDrv          <= '0;
      dsTrafficEn    <= 4'h0;
      dsLowRate      <= 4'h0;
      newConnect     <= 4'h0;
      epSizeMode     <= 2'h0;
      hubIrq         <= 1'b0;
      leaveSuspend   <= 1'b0;
      cpuHold        <= 1'b0;
      upResumeActive <= 1'b0;
    end else begin
      dsDrv          <= dsDrv_nxt;
      usDrv          <= usDrv_nxt;
      dsTrafficEn    <= portEnable & ~susp_r[3:0];
      dsLowRate      <= portLowSpeed;
      newConnect     <= {4{resEnd}} & portConnected & ~portEnable & se0;
      epSizeMode     <= usc_r[7:6];
      hubIrq         <= (|resSet) | wakeEvt | hostRes;
      leaveSuspend   <= wakeEvt;
      cpuHold        <= (wk_nxt == WK_HOLD);
      upResumeActive <= resumeAll;
    end
  end

endmodule

`default_nettype wire

// ---- dv/hpsr_top_assertions.sv ----
// Concurrent checks on the hub port suspend/resume top ports
`timescale 1ns/100ps
`default_nettype none

module hpsr_top_chk #(
  parameter int WAKE_HOLD_CYC = 8
) (
  // Clock and reset
  input wire logic                    mclk,
  input wire logic                    rstn,
  // Register bus
  input wire hpsr_pkg::hpsr_ahb_req_t ahbReq,
  input wire hpsr_pkg::hpsr_ahb_rsp_t ahbRsp,
  // Ports and power
  input wire logic [3:0]              portEnable,
  input wire logic [3:0]              portLowSpeed,
  input wire logic [3:0]              connEvt,
  input wire logic [3:0]              discEvt,
  input wire logic [3:0]              dsTrafficEn,
  input wire logic [3:0]              dsLowRate,
  input wire logic                    hubSuspended,
  input wire logic                    hubIrq,
  input wire logic                    leaveSuspend,
  input wire logic                    cpuHold
);
  import hpsr_pkg::*;
  wire logic taken;
  int        holdCnt_r;
  assign taken = ahbReq.hsel && ahbReq.htrans[1] && ahbRsp.hreadyout;
  // Counts how long firmware has been held off
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      holdCnt_r <= 0;
    end else begin
      holdCnt_r <= cpuHold ? holdCnt_r + 1 : 0;
    end
  end
  // ********************
  // Properties
  // ********************
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_read_wait: assert property (taken && !ahbReq.hwrite |=> !ahbRsp.hreadyout ##1 ahbRsp.hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (taken && ahbReq.hwrite |=> ahbRsp.hreadyout)
    else $error("write stalled");
  a_resp_okay: assert property (!ahbRsp.hresp)
    else $error("error response");
  a_traffic_gate: assert property ((dsTrafficEn & ~$past(portEnable)) == 4'h0)
    else $error("traffic to disabled port");
  a_wake_pulse: assert property (hubSuspended && |(connEvt | discEvt) |=> leaveSuspend && hubIrq)
    else $error("port change did not wake");
  a_irq_wake: assert property ($rose(leaveSuspend) |-> hubIrq)
    else $error("wake without interrupt");
  a_hold_start: assert property ($rose(leaveSuspend) |-> ##[0:1] cpuHold)
    else $error("firmware not held");
  a_hold_len: assert property ($fell(cpuHold) |-> holdCnt_r >= WAKE_HOLD_CYC)
    else $error("hold too short");
  a_low_rate: assert property ($past(rstn) |-> dsLowRate == $past(portLowSpeed))
    else $error("edge rate not following speed");
endmodule

bind hpsr_top hpsr_top_chk #(.WAKE_HOLD_CYC(WAKE_HOLD_CYC)) u_chk (
  .mclk(mclk), .rstn(rstn), .ahbReq(ahbReq), .ahbRsp(ahbRsp), .portEnable(portEnable),
  .portLowSpeed(portLowSpeed), .connEvt(connEvt), .discEvt(discEvt), .dsTrafficEn(dsTrafficEn),
  .dsLowRate(dsLowRate), .hubSuspended(hubSuspended), .hubIrq(hubIrq),
  .leaveSuspend(leaveSuspend), .cpuHold(cpuHold));

`default_nettype wire

// ---- dv/hpsr_dev_model.sv ----
// Line model of four downstream devices
`timescale 1ns/100ps
`default_nettype none

module hpsr_dev_model (
  // Clock
  input  wire logic                       mclk,
  // Device controls
  input  wire logic [3:0]                 attached,
  input  wire logic [3:0]                 lowSpeed,
  input  wire logic [3:0]                 wakeK,
  // Port lines
  output var  hpsr_pkg::hpsr_line_t [3:0] dsLine
);
  import hpsr_pkg::*;
  initial dsLine = '0;
  always @(posedge mclk) begin
    for (int i = 0; i < 4; i++) begin
      if (!attached[i]) begin
        // Pull-downs leave a detached port at SE0
        dsLine[i] <= 2'b00;
      end else begin
        // Idle J or held K; polarity swaps with speed
        dsLine[i] <= {!(lowSpeed[i] ^ wakeK[i]), lowSpeed[i] ^ wakeK[i]};
      end
    end
  end
endmodule

`default_nettype wire

// ---- dv/hpsr_top_bench.sv ----
// Self-checking bench for the hub port suspend/resume block
`timescale 1ns/100ps
`default_nettype none

module hub_port_suspend_resume_bench;
  import hpsr_pkg::*;
  logic                mclk, rstn, busReset, sieActivity, hubSuspended;
  logic                hubIrq, leaveSuspend, cpuHold, upResumeActive;
  logic [3:0]          portEnable, portLowSpeed, attached, connected, wakeK, connEvt, discEvt;
  logic [3:0]          dsTrafficEn, dsLowRate, newConnect;
  logic [1:0]          epSizeMode;
  hpsr_ahb_req_t       ahbReq;
  hpsr_ahb_rsp_t       ahbRsp;
  hpsr_line_t [3:0]    dsLine;
  hpsr_line_t          usLine;
  hpsr_drv_t [3:0]     rptDrv, dsDrv;
  hpsr_drv_t           sieDrv, usDrv;
  int                  failures, checksDone;
  logic [3:0]          expUa [8] = '{4'h6, 4'hb, 4'h7, 4'h3, 4'h3, 4'h1, 4'h2, 4'h0};
  logic [3:0]          expDs [4] = '{4'h6, 4'hb, 4'h7, 4'h3};

  hpsr_top #(.WAKE_HOLD_CYC(8), .UPK_CYC(16)) i_dut (
    .mclk(mclk), .rstn(rstn), .busReset(busReset), .ahbReq(ahbReq), .ahbRsp(ahbRsp),
    .dsLine(dsLine), .rptDrv(rptDrv), .portEnable(portEnable), .portLowSpeed(portLowSpeed),
    .portConnected(connected), .connEvt(connEvt), .discEvt(discEvt), .dsDrv(dsDrv),
    .dsTrafficEn(dsTrafficEn), .dsLowRate(dsLowRate), .newConnect(newConnect), .usLine(usLine),
    .sieDrv(sieDrv), .sieActivity(sieActivity), .usDrv(usDrv), .epSizeMode(epSizeMode),
    .hubSuspended(hubSuspended), .hubIrq(hubIrq), .leaveSuspend(leaveSuspend),
    .cpuHold(cpuHold), .upResumeActive(upResumeActive));
  hpsr_dev_model i_dev (.mclk(mclk), .attached(attached), .lowSpeed(portLowSpeed),
    .wakeK(wakeK), .dsLine(dsLine));

  always #25 mclk = ~mclk;

  // ********************
  // Tasks
  // ********************
  task automatic testDone();
    $display("checks %0d mismatches %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checksDone++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Bounded wait for hready sampled high at an edge
  task automatic waitRdy();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (ahbRsp.hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      testDone();
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wv,
                      output logic [7:0] rv);
    ahbReq.hsel   <= 1'b1;
    ahbReq.haddr  <= {22'h0, idx, 2'b00};
    ahbReq.htrans <= 2'h2;
    ahbReq.hwrite <= w;
    ahbReq.hsize  <= 3'h2;
    waitRdy();
    ahbReq.htrans <= 2'h0;
    ahbReq.hwdata <= {24'h0, wv};
    waitRdy();
    rv = ahbRsp.hrdata[7:0];
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    logic [7:0] d;
    xfer(1'b1, idx, v, d);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    logic [7:0] d;
    xfer(1'b0, idx, 8'h00, d);
    cmp(d, e);
  endtask
  // Collects upstream resume, interrupt and wake over a window
  task automatic watch(input int n, output logic [2:0] seen);
    seen = 3'h0;
    repeat (n) begin
      @(posedge mclk);
      seen |= {upResumeActive, hubIrq, leaveSuspend};
    end
  endtask

  initial begin
    logic [2:0] s;
    logic [3:0] m;
    mclk = 0; rstn = 0; busReset = 0; ahbReq = '0; rptDrv = {4{4'h6}}; sieDrv = 4'h6;
    portEnable = 4'hf; portLowSpeed = 4'h2; attached = 4'h7; wakeK = 0; connEvt = 0;
    discEvt = 0; usLine = 2'b10; sieActivity = 0; hubSuspended = 0; failures = 0; checksDone = 0;
    connected = 4'h7;
    tick(20);
    rstn <= 1'b1;
    tick(1);
    rd(8'h1f, 8'h20);
    foreach (expDs[i]) rd(8'(i == 0 ? 8'h4b : 8'h4c + i), 8'h00);
    rd(8'h50, 8'h05);
    attached[0] <= 1'b0;
    tick(4);
    rd(8'h50, 8'h05);
    attached[0] <= 1'b1;
    wr(8'h4e, 8'hff);
    wr(8'h60, 8'hff);
    rd(8'h4e, 8'h00);
    rd(8'h60, 8'h00);
    wr(8'h4d, 8'hff);
    rd(8'h4d, 8'hff);
    wr(8'h4d, 8'h00);
    $display("test registers done");
    sieActivity <= 1'b1;
    tick(1);
    sieActivity <= 1'b0;
    tick(1);
    rd(8'h1f, 8'h28);
    wr(8'h1f, 8'h08);
    rd(8'h1f, 8'h28);
    wr(8'h1f, 8'h00);
    rd(8'h1f, 8'h20);
    for (int a = 0; a < 8; a++) begin
      wr(8'h1f, 8'(a));
      tick(2);
      m = {expUa[a][1:0], 2'b11};
      cmp({4'h0, usDrv & m}, {4'h0, expUa[a] & m});
    end
    wr(8'h1f, 8'hc0);
    tick(2);
    cmp({6'h0, epSizeMode}, 8'h03);
    wr(8'h1f, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(8'h4b, 8'(c << 4));
      tick(2);
      cmp({4'h0, dsDrv[2]}, {4'h0, expDs[c]});
    end
    wr(8'h4b, 8'h00);
    $display("test upstream and control done");
    wr(8'h4d, 8'h0a);
    tick(2);
    cmp({4'h0, dsTrafficEn}, 8'h05);
    cmp({4'h0, dsDrv[1]}, 8'h00);
    wakeK[1] <= 1'b1;
    watch(80, s);
    wakeK[1] <= 1'b0;
    cmp({7'h0, s[1]}, 8'h01);
    rd(8'h4e, 8'h02);
    cmp({4'h0, dsDrv[1]}, 8'h0b);
    cmp({4'h0, dsDrv[3]}, 8'h00);
    // Firmware resume sequence; times scaled down to fit the run budget
    wr(8'h4b, 8'h04);
    tick(40);
    portEnable[1] <= 1'b0;
    wr(8'h4d, 8'h08);
    rd(8'h4e, 8'h00);
    tick(2);
    cmp({4'h0, dsDrv[1]}, 8'h0b);
    wr(8'h4b, 8'h0c);
    tick(2);
    cmp({4'h0, dsDrv[1]}, 8'h03);
    wr(8'h4b, 8'h08);
    tick(2);
    cmp({4'h0, dsDrv[1]}, 8'h07);
    wr(8'h4b, 8'h00);
    portEnable[1] <= 1'b1;
    tick(2);
    cmp({4'h0, dsDrv[1]}, 8'h06);
    discEvt <= 4'h8;
    tick(1);
    discEvt <= 4'h0;
    tick(2);
    rd(8'h4d, 8'h00);
    wr(8'h4d, 8'h83);
    busReset <= 1'b1;
    tick(1);
    busReset <= 1'b0;
    rd(8'h4d, 8'h00);
    $display("test selective suspend done");
    hubSuspended <= 1'b1;
    tick(40);
    connEvt <= 4'h4;
    tick(1);
    connEvt <= 4'h0;
    watch(40, s);
    cmp({5'h0, s}, 8'h03);
    wr(8'h4d, 8'h80);
    connEvt <= 4'h4;
    tick(1);
    connEvt <= 4'h0;
    watch(40, s);
    cmp({5'h0, s}, 8'h07);
    wr(8'h4d, 8'h00);
    tick(40);
    wakeK[0] <= 1'b1;
    watch(80, s);
    wakeK[0] <= 1'b0;
    cmp({5'h0, s}, 8'h07);
    hubSuspended <= 1'b0;
    $display("test hub wake done");
    // Port 3 disabled, reported connected, line at SE0; host holds K
    portEnable[3] <= 1'b0;
    connected[3] <= 1'b1;
    usLine <= 2'b01;
    tick(60);
    cmp({7'h0, upResumeActive}, 8'h01);
    cmp({4'h0, dsDrv[2]}, 8'h07);
    usLine <= 2'b10;
    m = 4'h0;
    repeat (8) begin
      @(posedge mclk);
      m |= newConnect;
    end
    cmp({4'h0, m}, 8'h08);
    $display("test resume end done");
    testDone();
  end
endmodule

`default_nettype wire
